// >>> inc/sps_defines.svh
// constants of the servo amplifier power-up sequencer
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// ----------------------------------------------------------------
// clocks and timing
// ----------------------------------------------------------------
`define SPS_CLK_HZ          25000000
`define SPS_TMR_HZ          1250000
`define SPS_TMR_DIV         (`SPS_CLK_HZ / `SPS_TMR_HZ)
`define SPS_T1_MAX_A        16'h07d0
`define SPS_T2_MAX_A        16'h02b2
`define SPS_T1_PERIOD_US    1600
`define SPS_T2_PERIOD_US    552
`define SPS_T1_PER_SEC      625
`define SPS_RESET_SECS      2'd1
`define SPS_SETTLE_SECS     2'd3
`define SPS_FAULT_SECS      2'd3

// ----------------------------------------------------------------
// timer register file
// ----------------------------------------------------------------
`define SPS_TMR_BASE        8'h50
`define SPS_TMR_STEP        8'h02
`define SPS_TMR_WRITES      4'd12
`define SPS_T2_MISSING      8'h64
`define SPS_MODE_IDLE       16'h4000
`define SPS_MODE_T1_RUN     16'he009
`define SPS_MODE_T2_RUN     16'hc001
`define SPS_MODE_EN_BIT     0
`define SPS_MODE_PERMIT_BIT 14

// ----------------------------------------------------------------
// port bits and status masks
// ----------------------------------------------------------------
`define SPS_AMP_RESET_MASK  16'h2000
`define SPS_CONTACTOR_MASK  16'h8000
`define SPS_ROT_FAULT_MASK  16'h0101
`define SPS_FOCUS_FAULT_BIT 0
`define SPS_BUS_FAULT_FLAG  16'h0001

// ----------------------------------------------------------------
// apb register offsets
// ----------------------------------------------------------------
`define SPS_REG_CTRL        12'h000
`define SPS_REG_STATUS      12'h004
`define SPS_REG_FAULT       12'h008
`define SPS_REG_IDENT       12'h00c
`define SPS_REG_IRQ_STAT    12'h010
`define SPS_REG_IRQ_EN      12'h014
`define SPS_REG_IRQ_CLR     12'h018
`define SPS_REG_PORT        12'h01c
`define SPS_IDENT_DEFAULT   16'h5a01 // arbitrary identity value

`endif

// >>> inc/sps_pkg.sv
// types of the servo amplifier power-up sequencer
package sps_pkg;
  typedef enum logic [3:0] {
    SPS_IDLE,
    SPS_TMR_OFF,
    SPS_RESET_AMP,
    SPS_SETTLE,
    SPS_POWER_ON,
    SPS_POWER_SETTLE,
    SPS_FAULT_POLL,
    SPS_FAULT_LATCH,
    SPS_HEALTHY_OFF,
    SPS_APEX_REQ,
    SPS_APEX_WAIT,
    SPS_EXEC
  } sps_state_t;

  typedef enum logic [1:0] {
    SPS_TO_NONE,
    SPS_TO_BOOT,
    SPS_TO_HEALTHY
  } sps_after_off_t;
endpackage

// >>> hw/sps_timer.sv
// one interval timer with max count a and a write-protected mode register
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_timer
  import sps_pkg::*;
(
  input  wire logic        pclk,       // system clock
  input  wire logic        presetn,    // async reset, low
  input  wire logic        tick,       // 1.25 mhz count strobe
  input  wire logic        mode_we,    // mode register write
  input  wire logic        max_we,     // max count a write
  input  wire logic [15:0] wdata,      // write data
  output logic             running,    // counting
  output logic             expire      // one-cycle timeout pulse
);
  logic [15:0] max_q;
  logic [15:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_q <= 16'h0001;
    end else if (max_we) begin
      max_q <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
    end else if (mode_we && wdata[`SPS_MODE_PERMIT_BIT]) begin
      running <= wdata[`SPS_MODE_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0000;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (!running) begin
        cnt_q <= 16'h0000;
      end else if (tick) begin
        if (cnt_q + 16'h0001 >= max_q) begin
          cnt_q  <= 16'h0000;
          expire <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule

// >>> hw/sps_sequencer.sv
// servo amplifier power-up and bus-fault sequencer with apb registers
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_sequencer
  import sps_pkg::*;
#(
  parameter int T1_PER_SEC = `SPS_T1_PER_SEC,         // timer 1 periods per second
  parameter logic [15:0] IDENT = `SPS_IDENT_DEFAULT   // arbitrary identity value
)(
  input  wire logic        pclk,          // system clock, 25 mhz
  input  wire logic        presetn,       // async reset, low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb write
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic [15:0] amp_status_n,  // low-true amplifier status pins
  input  wire logic        apex_valid,    // apex data arrived
  output logic             apex_req,      // apex data request pulse
  output logic      [15:0] port_out,      // output port a/b bits
  output logic             amp_reset_n,   // amplifier reset, low true
  output logic             irq            // level interrupt
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sps_state_t      state_q;
  sps_after_off_t  after_q;
  logic [15:0] port_q;
  logic [15:0] amplifier_fault_word_q;
  logic [15:0] unit_identity_word_q;
  logic        timer_expiry_flag_q;
  logic [1:0]  secs_q;
  logic [9:0]  sec_cnt_q;
  logic [3:0]  wr_idx_q;
  logic [4:0]  div_q;
  logic        start_q, axis_rot_q;
  logic [2:0]  irq_stat_q, irq_en_q;
  logic [15:0] st_s1v_q, st_s2_q;
  logic        ap_s1_q, ap_s2_q;
  logic        tick, bus_fault, t1_exp, t1_run, t2_run, sec_done;
  logic        t_mode_we [3];
  logic        t_max_we  [3];
  logic [15:0] t_wdata;
  logic [7:0]  t_addr;
  logic [2:0]  ev;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_s1v_q <= 16'hffff;
      st_s2_q  <= 16'hffff;
      ap_s1_q  <= 1'b0;
      ap_s2_q  <= 1'b0;
    end else begin
      st_s1v_q <= amp_status_n;
      st_s2_q  <= st_s1v_q;
      ap_s1_q  <= apex_valid;
      ap_s2_q  <= ap_s1_q;
    end
  end
  assign bus_fault = axis_rot_q ? ((~st_s2_q & `SPS_ROT_FAULT_MASK) != 16'h0000)
                                : ~st_s2_q[`SPS_FOCUS_FAULT_BIT];

  // ----------------------------------------------------------------
  // timer clock prescaler and timers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 5'd0;
    end else if (div_q == 5'(`SPS_TMR_DIV - 1)) begin
      div_q <= 5'd0;
    end else begin
      div_q <= div_q + 5'd1;
    end
  end
  assign tick = (div_q == 5'(`SPS_TMR_DIV - 1));

  assign t_addr = 8'(`SPS_TMR_BASE + {wr_idx_q, 1'b0});

  // shutdown table, one word per slot
  // mode words 4000h
  always_comb begin
    case (wr_idx_q)
      4'd3:    t_wdata = `SPS_MODE_IDLE;
      4'd5:    t_wdata = `SPS_T1_MAX_A;
      4'd7:    t_wdata = `SPS_MODE_IDLE;
      4'd9:    t_wdata = `SPS_T2_MAX_A;
      4'd11:   t_wdata = `SPS_MODE_IDLE;
      default: t_wdata = 16'h0000;
    endcase
  end

  // twelve writes, slot at 64h decodes to nothing
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      t_mode_we[i] = 1'b0;
      t_max_we[i]  = 1'b0;
    end
    if (state_q == SPS_TMR_OFF) begin
      case (t_addr)
        8'h56:   t_mode_we[0] = 1'b1;
        8'h5a:   t_max_we[1]  = 1'b1;
        8'h5e:   t_mode_we[1] = 1'b1;
        8'h62:   t_max_we[2]  = 1'b1;
        8'h66:   t_mode_we[2] = 1'b1;
        default: ;
      endcase
    end else if (start_q) begin
      t_mode_we[1] = 1'b1;
      t_mode_we[2] = 1'b1;
    end
  end

  logic [15:0] t_bus [3];
  always_comb begin
    t_bus[0] = t_wdata;
    t_bus[1] = start_q ? `SPS_MODE_T1_RUN : t_wdata;
    t_bus[2] = start_q ? `SPS_MODE_T2_RUN : t_wdata;
  end

  logic t_exp [3];
  logic t_run [3];
  for (genvar g = 0; g < 3; g++) begin : g_tmr
    sps_timer u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .mode_we (t_mode_we[g]),
      .max_we  (t_max_we[g]),
      .wdata   (t_bus[g]),
      .running (t_run[g]),
      .expire  (t_exp[g])
    );
  end
  assign t1_exp = t_exp[1];
  assign t1_run = t_run[1];
  assign t2_run = t_run[2];

  // ----------------------------------------------------------------
  // one-second wait built from timer 1 periods
  // ----------------------------------------------------------------
  assign sec_done = t1_exp && (sec_cnt_q == 10'(T1_PER_SEC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_q <= 10'd0;
    end else if (start_q) begin
      sec_cnt_q <= 10'd0;
    end else if (t1_exp) begin
      sec_cnt_q <= sec_done ? 10'd0 : sec_cnt_q + 10'd1;
    end
  end

  // expiry sets the flag; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_expiry_flag_q <= 1'b0;
    end else if (sec_done) begin
      timer_expiry_flag_q <= 1'b1;
    end else if (start_q) begin
      timer_expiry_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic flag_seen;
  assign flag_seen = timer_expiry_flag_q && !start_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= SPS_IDLE;
      after_q  <= SPS_TO_NONE;
      wr_idx_q <= 4'd0;
      secs_q   <= 2'd0;
      start_q  <= 1'b0;
      apex_req <= 1'b0;
    end else begin
      start_q  <= 1'b0;
      apex_req <= 1'b0;
      case (state_q)
        SPS_IDLE: begin
          if (psel && penable && pwrite && paddr == `SPS_REG_CTRL && pwdata[0]) begin
            state_q  <= SPS_TMR_OFF;
            after_q  <= SPS_TO_BOOT;
            wr_idx_q <= 4'd0;
          end
        end
        SPS_TMR_OFF: begin
          if (wr_idx_q == `SPS_TMR_WRITES - 4'd1) begin
            wr_idx_q <= 4'd0;
            if (after_q == SPS_TO_HEALTHY) begin
              state_q <= SPS_APEX_REQ;
            end else begin
              state_q <= SPS_RESET_AMP;
              secs_q  <= `SPS_RESET_SECS;
              start_q <= 1'b1;
            end
          end else begin
            wr_idx_q <= wr_idx_q + 4'd1;
          end
        end
        SPS_RESET_AMP, SPS_SETTLE, SPS_POWER_SETTLE: begin
          // one timeout per second, flag cleared before each
          if (flag_seen) begin
            if (secs_q == 2'd1) begin
              start_q <= 1'b1;
              case (state_q)
                SPS_RESET_AMP: begin
                  state_q <= SPS_SETTLE;
                  secs_q  <= `SPS_SETTLE_SECS;
                end
                SPS_SETTLE: begin
                  state_q <= SPS_POWER_ON;
                end
                default: begin
                  state_q <= SPS_FAULT_POLL;
                  secs_q  <= `SPS_FAULT_SECS;
                end
              endcase
            end else begin
              secs_q  <= secs_q - 2'd1;
              start_q <= 1'b1;
            end
          end
        end
        SPS_POWER_ON: begin
          state_q <= SPS_POWER_SETTLE;
          secs_q  <= `SPS_SETTLE_SECS;
          start_q <= 1'b1;
        end
        SPS_FAULT_POLL: begin
          if (!bus_fault) begin
            state_q  <= SPS_TMR_OFF;
            after_q  <= SPS_TO_HEALTHY;
            wr_idx_q <= 4'd0;
          end else if (flag_seen) begin
            if (secs_q == 2'd1) begin
              state_q <= SPS_FAULT_LATCH;
            end else begin
              secs_q  <= secs_q - 2'd1;
              start_q <= 1'b1;
            end
          end
        end
        SPS_FAULT_LATCH: begin
          state_q <= SPS_POWER_ON;
        end
        SPS_APEX_REQ: begin
          apex_req <= 1'b1;
          state_q  <= SPS_APEX_WAIT;
        end
        SPS_APEX_WAIT: begin
          if (ap_s2_q) begin
            state_q <= SPS_EXEC;
          end
        end
        SPS_EXEC: ;
        default: state_q <= SPS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // port bits, fault word, identity
  // ----------------------------------------------------------------
  // reset active during one second
  // or in 2000h, keep other bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_q <= 16'h0000;
    end else if (state_q == SPS_TMR_OFF && after_q == SPS_TO_BOOT &&
                 wr_idx_q == `SPS_TMR_WRITES - 4'd1) begin
      port_q <= port_q | `SPS_AMP_RESET_MASK;
    end else if (state_q == SPS_SETTLE && start_q) begin
      port_q <= port_q & ~`SPS_AMP_RESET_MASK;
    end else if (state_q == SPS_POWER_ON) begin
      port_q <= `SPS_CONTACTOR_MASK;
    end else if (psel && penable && pwrite && paddr == `SPS_REG_PORT &&
                 state_q == SPS_EXEC) begin
      port_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amplifier_fault_word_q <= 16'h0000;
      unit_identity_word_q   <= 16'h0000;
    end else begin
      if (state_q == SPS_FAULT_LATCH) begin
        amplifier_fault_word_q <= amplifier_fault_word_q | `SPS_BUS_FAULT_FLAG;
      end else if (state_q == SPS_TMR_OFF && after_q == SPS_TO_HEALTHY &&
                   wr_idx_q == 4'd0) begin
        amplifier_fault_word_q <= 16'h0000;
      end
      if (state_q == SPS_APEX_REQ) begin
        unit_identity_word_q <= IDENT;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts: latch, reset start, executive reached
  // ----------------------------------------------------------------
  assign ev = {state_q == SPS_APEX_WAIT && ap_s2_q,
               state_q == SPS_RESET_AMP && start_q,
               state_q == SPS_FAULT_LATCH};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'h0;
      irq_en_q   <= 3'h0;
      axis_rot_q <= 1'b0;
    end else begin
      if (psel && penable && pwrite && paddr == `SPS_REG_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (psel && penable && pwrite && paddr == `SPS_REG_IRQ_EN) begin
        irq_en_q <= pwdata[2:0];
      end
      if (psel && penable && pwrite && paddr == `SPS_REG_CTRL) begin
        axis_rot_q <= pwdata[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `SPS_REG_CTRL:     prdata <= {30'h0, axis_rot_q, 1'b0};
          `SPS_REG_STATUS:   prdata <= {20'h0, t2_run, t1_run, timer_expiry_flag_q,
                                        secs_q, 3'h0, state_q};
          `SPS_REG_FAULT:    prdata <= {16'h0, amplifier_fault_word_q};
          `SPS_REG_IDENT:    prdata <= {16'h0, unit_identity_word_q};
          `SPS_REG_IRQ_STAT: prdata <= {29'h0, irq_stat_q};
          `SPS_REG_IRQ_EN:   prdata <= {29'h0, irq_en_q};
          `SPS_REG_IRQ_CLR:  prdata <= 32'h0000_0000;
          `SPS_REG_PORT:     prdata <= {16'h0, port_q};
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out    <= 16'h0000;
      amp_reset_n <= 1'b1;
      irq         <= 1'b0;
    end else begin
      port_out    <= port_q;
      amp_reset_n <= ~port_q[13];
      irq         <= |(irq_stat_q & irq_en_q);
    end
  end
endmodule

// >>> verif/sps_seq_properties.sv
// port checker of the power-up sequencer
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_seq_properties #(
  parameter int T1_PER_SEC = 625  // timer 1 periods per second
)(
  input wire logic        pclk,        // clock
  input wire logic        presetn,     // reset, low
  input wire logic        psel,        // apb select
  input wire logic        penable,     // apb enable
  input wire logic        pready,      // apb ready
  input wire logic        pslverr,     // apb error
  input wire logic [31:0] prdata,      // apb read data
  input wire logic        apex_req,    // apex request
  input wire logic [15:0] port_out,    // port bits
  input wire logic        amp_reset_n  // amplifier reset
);
  localparam int SEC = T1_PER_SEC * 2000 * `SPS_TMR_DIV;
  int low_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------
  // reset pulse length
  // --------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 0;
    end else begin
      low_q <= amp_reset_n ? 0 : low_q + 1;
    end
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_reset_cmd_pin: assert property ($rose(port_out[13]) |-> ##[0:2] !amp_reset_n)
    else $error("reset pin not following port bit");
  a_reset_release: assert property ($fell(port_out[13]) |-> ##[0:2] amp_reset_n)
    else $error("reset pin not released");
  a_reset_length: assert property ($rose(amp_reset_n) |-> low_q >= SEC - 40 && low_q <= SEC + 40)
    else $error("reset pulse length wrong");
  a_apex_req_pulse: assert property (apex_req |=> !apex_req)
    else $error("apex request longer than one cycle");
  a_contactor_alone: assert property ($rose(port_out[15]) |-> port_out == 16'h8000 && amp_reset_n)
    else $error("contactor drive with other bits");
  c_reset_pulse: cover property ($fell(amp_reset_n));
  c_refused: cover property (pslverr);
  c_access: cover property (pready && psel);
endmodule

// >>> verif/sps_amp_model.sv
// behavioural servo amplifier and apex link model
`timescale 1ns/1ps
module sps_amp_model (
  input  wire logic        pclk,         // clock
  input  wire logic        presetn,      // reset, low
  input  wire logic        amp_reset_n,  // amplifier reset
  input  wire logic        contactor,    // power on
  input  wire logic        bus_fault,    // inject fault
  input  wire logic        apex_req,     // data request
  output logic      [15:0] amp_status_n, // low-true status
  output logic             apex_valid    // data arrived
);
  logic [15:0] junk_q;
  logic [3:0]  dly_q;
  // --------------------------------
  // status pins
  // --------------------------------
  // bus-fault bits read 0 on fault
  always_comb begin
    amp_status_n    = junk_q;
    amp_status_n[0] = contactor && !bus_fault;
    amp_status_n[8] = contactor && !bus_fault;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      junk_q     <= 16'h5a5a;
      dly_q      <= 4'h0;
      apex_valid <= 1'b0;
    end else begin
      junk_q <= amp_reset_n ? junk_q : ~junk_q;
      if (apex_req) begin
        dly_q      <= 4'h9;
        apex_valid <= 1'b0;
      end else if (dly_q != 4'h0) begin
        dly_q      <= dly_q - 4'h1;
        apex_valid <= (dly_q == 4'h1);
      end
    end
  end
endmodule

// >>> verif/testbench.sv
// self-checking bench of the power-up sequencer
`timescale 1ns/1ps
`include "sps_defines.svh"
module testbench;
  import sps_pkg::*;
  localparam int T1PS = 1;
  localparam int SEC  = T1PS * 2000 * `SPS_TMR_DIV;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic apex_valid, apex_req, amp_reset_n, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] amp_status_n, port_out;
  logic err;
  int errors, comparisons, cyc, fall_at;
  sps_sequencer #(.T1_PER_SEC(T1PS)) sps_sequencer_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .amp_status_n(amp_status_n),
    .apex_valid(apex_valid), .apex_req(apex_req), .port_out(port_out),
    .amp_reset_n(amp_reset_n), .irq(irq));
  sps_amp_model sps_amp_model_inst (.pclk(pclk), .presetn(presetn),
    .amp_reset_n(amp_reset_n), .contactor(port_out[15]), .bus_fault(1'b0),
    .apex_req(apex_req), .amp_status_n(amp_status_n), .apex_valid(apex_valid));
  always #20 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_idle();
    apb(1'b0, `SPS_REG_STATUS, 32'h0);
    check("state", q[11:0] & 12'hc0f, 12'h000);
    check("port", port_out, 16'h0000);
    check("rst pin", amp_reset_n, 1'b1);
    check("irq", irq, 1'b0);
    $display("test idle done");
  endtask
  task automatic t_refuse();
    apb(1'b0, 12'h020, 32'h0);
    check("slverr", err, 1'b1);
    apb(1'b1, `SPS_REG_PORT, 32'hffff);
    @(posedge pclk);
    check("port locked", port_out, 16'h0000);
    $display("test refuse done");
  endtask
  task automatic t_boot();
    int n;
    apb(1'b1, `SPS_REG_IRQ_EN, 32'h2);
    apb(1'b1, `SPS_REG_CTRL, 32'h1);
    n = 0;
    while (amp_reset_n !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    fall_at = cyc;
    check("shutdown span", n >= 11 && n <= 20, 1'b1);
    check("reset port", port_out, `SPS_AMP_RESET_MASK);
    apb(1'b0, `SPS_REG_STATUS, 32'h0);
    check("t1 running", q[10], 1'b1);
    apb(1'b1, `SPS_REG_CTRL, 32'h2);
    apb(1'b0, `SPS_REG_CTRL, 32'h0);
    check("axis select", q[1:0], 2'b10);
    check("irq set", irq, 1'b1);
    apb(1'b1, `SPS_REG_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    check("irq masked", irq, 1'b0);
    apb(1'b1, `SPS_REG_IRQ_EN, 32'h2);
    repeat (2) @(posedge pclk);
    check("irq unmasked", irq, 1'b1);
    apb(1'b1, `SPS_REG_IRQ_CLR, 32'h2);
    repeat (2) @(posedge pclk);
    check("irq cleared", irq, 1'b0);
    $display("test boot done");
  endtask
  task automatic t_reset_len();
    int n;
    n = 0;
    while (amp_reset_n !== 1'b1 && n < SEC + 200) begin
      @(posedge pclk);
      n++;
    end
    n = cyc - fall_at;
    check("reset length", n >= SEC - 40 && n <= SEC + 40, 1'b1);
    repeat (3) @(posedge pclk);
    check("reset bit off", port_out[13], 1'b0);
    $display("test reset length done");
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    comparisons = 0;
    cyc = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_idle();
    t_refuse();
    t_boot();
    t_reset_len();
    wrap_up();
  end
  initial begin
    repeat (SEC + 20000) @(posedge pclk);
    errors++;
    wrap_up();
  end
endmodule
bind sps_sequencer sps_seq_properties #(.T1_PER_SEC(T1_PER_SEC)) chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .apex_req(apex_req), .port_out(port_out), .amp_reset_n(amp_reset_n));
